// ===== rtl/transceiver_pin_ctrl.sv
// Purpose: Set selection, data pin steering, bit clock, pattern match and clock divider.
// Assumes: All pin inputs are synchronous to clk; clk is the reference crystal clock.
// Notes: Configuration registers are reachable both over APB and over the 3-wire serial port; the interrupt registers over APB only.
// Summary of operation
// - Two stored five-parameter sets kept
// - Register bit picks set when external select off
// - Select pin picks set when external select on
// - Select pin is two-way, chooses stored set
// - Reference clock divided by 4, 8, 16, 32
// - Bidirectional data: pin in on transmit, out on receive
// - Bidirectional off: pin only receive output
// - Transmit-only input used only without bidirectional
// - Pattern output high on reference pattern match
// - Serial port: clock, data in, data out, enable
// - Receive bit clock output provided
// - Serial access only while enable held low
// - External select bit is bit 3 index 2
// - Select pin output high only in transmit
// - Set select register one bit, index 0
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module transceiver_pin_ctrl
    import radio_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // APB slave.
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Three-wire serial port.
    input  wire serial_pins_s      serial_in,
    output logic                   serial_out,
    output logic                   serial_out_oe,
    // Set select pin.
    input  wire logic              set_sel_i,
    output logic                   set_sel_o,
    output logic                   set_sel_oe,
    // Shared data pin and transmit-only input.
    input  wire logic              data_i,
    output logic                   data_o,
    output logic                   data_oe,
    input  wire logic              transmit_only_input,
    // Radio core side.
    input  wire logic              rx_bit,
    input  wire logic              rx_bit_valid,
    output logic                   tx_bit,
    output param_set_s             active_params,
    // Status outputs.
    output logic                   receive_bit_clock,
    output logic                   pattern_match,
    output logic                   divided_ref_clock_out,
    output logic                   irq
);

    logic [7:0]           cfg_reg [REG_DEPTH];
    logic [IRQ_W-1:0]     irq_status_reg;
    logic [IRQ_W-1:0]     irq_mask_reg;
    param_set_s           params_reg;
    logic                 active_set_reg;
    logic                 set_sel_o_reg;
    logic                 tx_bit_reg;
    logic                 rx_data_reg;
    logic                 bclk_reg;
    logic [PAT_W-1:0]     rx_shift_reg;
    logic [5:0]           rx_fill_reg;
    logic                 match_reg;
    logic [4:0]           div_cnt_reg;
    logic                 div_out_reg;
    logic [31:0]          prdata_reg;
    ser_state_e           ser_state_reg;
    logic [3:0]           ser_cnt_reg;
    logic [7:0]           ser_shift_reg;
    logic [7:0]           ser_out_reg;
    logic                 ser_rw_reg;
    logic [4:0]           ser_addr_reg;
    logic                 ser_wr_reg;
    logic                 sck_prev_reg;

    logic                 ext_sel;
    logic                 set_pick;
    param_set_s           sel_set;
    logic                 bidir;
    logic                 tx_state;
    logic [1:0]           div_sel;
    logic [PAT_W-1:0]     pattern;
    logic                 match_next;
    logic [4:0]           apb_idx;
    logic                 apb_ok;
    logic                 apb_wr;
    logic                 sck_rise;
    logic [IRQ_W-1:0]     irq_event;
    // Byte view of the register space; the low status byte reports live state, the high one reads zero.
    function automatic logic [7:0] rd_byte(input logic [4:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (idx == IDX_STATUS_LO) begin
            val = {6'h00, active_set_reg, match_reg};
        end else if (idx == IDX_SET_SELECT) begin
            val = {7'h00, cfg_reg[idx][0]};
        end else if (idx <= IDX_LAST_CFG) begin
            val = cfg_reg[idx];
        end
        return val;
    endfunction : rd_byte
    function automatic logic writable(input logic [4:0] idx);
        return (idx <= IDX_LAST_CFG) && (idx != IDX_STATUS_LO) && (idx != IDX_STATUS_HI);
    endfunction : writable
    assign ext_sel  = cfg_reg[IDX_LINK_PARAM2][EXT_SEL_BIT];
    assign set_pick = ext_sel ? set_sel_i : cfg_reg[IDX_SET_SELECT][0];
    assign sel_set  = set_pick ?
        {cfg_reg[IDX_SET2_LO+5'd2], cfg_reg[IDX_SET2_LO+5'd1], cfg_reg[IDX_SET2_LO]} :
        {cfg_reg[IDX_SET1_LO+5'd2], cfg_reg[IDX_SET1_LO+5'd1], cfg_reg[IDX_SET1_LO]};
    assign bidir    = cfg_reg[IDX_ADD_PARAM1][BIDIR_BIT];
    assign div_sel  = cfg_reg[IDX_ADD_PARAM1][DIV_SEL_LSB+1:DIV_SEL_LSB];
    assign tx_state = (params_reg.mode == MODE_TX);
    assign pattern  = {cfg_reg[IDX_PATTERN_LO], cfg_reg[IDX_PATTERN_LO+5'd1],
                       cfg_reg[IDX_PATTERN_LO+5'd2], cfg_reg[IDX_PATTERN_LO+5'd3]};

    // APB decode: word aligned, index in bits 6:2, nothing above.
    assign apb_idx = paddr[6:2];
    assign apb_ok  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:7] == '0) &&
                     ((apb_idx <= IDX_LAST_CFG) || (apb_idx == IDX_IRQ_STATUS) ||
                      (apb_idx == IDX_IRQ_MASK));
    assign apb_wr  = psel && penable && pwrite && apb_ok;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !apb_ok;
    assign prdata  = prdata_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (apb_idx == IDX_IRQ_STATUS) begin
                prdata_reg <= {30'h0, irq_status_reg};
            end else if (apb_idx == IDX_IRQ_MASK) begin
                prdata_reg <= {30'h0, irq_mask_reg};
            end else if (apb_ok) begin
                prdata_reg <= {24'h00_0000, rd_byte(apb_idx)};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Configuration store; APB has priority over a serial write in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < REG_DEPTH; i++) begin
                cfg_reg[i] <= CFG_RESET;
            end
        end else if (apb_wr && writable(apb_idx)) begin
            cfg_reg[apb_idx] <= pwdata[7:0];
        end else if (ser_wr_reg && writable(ser_addr_reg)) begin
            cfg_reg[ser_addr_reg] <= ser_shift_reg;
        end
    end

    // Three-wire serial slave: R/W bit, five address bits, eight data bits, MSB first.
    assign sck_rise      = serial_in.sck && !sck_prev_reg;
    assign serial_out    = ser_out_reg[7];
    assign serial_out_oe = !serial_in.en_n && (ser_state_reg == SER_DATA) && ser_rw_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            sck_prev_reg  <= 1'b0;
            ser_state_reg <= SER_IDLE;
            ser_cnt_reg   <= 4'h0;
            ser_shift_reg <= 8'h00;
            ser_out_reg   <= 8'h00;
            ser_rw_reg    <= 1'b0;
            ser_addr_reg  <= 5'h00;
            ser_wr_reg    <= 1'b0;
        end else begin
            sck_prev_reg <= serial_in.sck;
            ser_wr_reg   <= 1'b0;
            if (serial_in.en_n) begin
                ser_state_reg <= SER_IDLE;
            end else begin
                unique case (ser_state_reg)
                    SER_IDLE: begin
                        ser_state_reg <= SER_HEAD;
                        ser_cnt_reg   <= 4'h0;
                    end
                    SER_HEAD: begin
                        if (sck_rise) begin
                            ser_shift_reg <= {ser_shift_reg[6:0], serial_in.si};
                            ser_cnt_reg   <= ser_cnt_reg + 4'h1;
                            if (ser_cnt_reg == HEAD_BITS - 4'h1) begin
                                ser_rw_reg    <= ser_shift_reg[4];
                                ser_addr_reg  <= {ser_shift_reg[3:0], serial_in.si};
                                ser_out_reg   <= rd_byte({ser_shift_reg[3:0], serial_in.si});
                                ser_cnt_reg   <= 4'h0;
                                ser_state_reg <= SER_DATA;
                            end
                        end
                    end
                    SER_DATA: begin
                        if (sck_rise) begin
                            ser_shift_reg <= {ser_shift_reg[6:0], serial_in.si};
                            ser_out_reg   <= {ser_out_reg[6:0], 1'b0};
                            ser_cnt_reg   <= ser_cnt_reg + 4'h1;
                            if (ser_cnt_reg == DATA_BITS - 4'h1) begin
                                ser_wr_reg    <= !ser_rw_reg;
                                ser_state_reg <= SER_DONE;
                            end
                        end
                    end
                    SER_DONE: begin
                        ser_state_reg <= SER_DONE;
                    end
                endcase
            end
        end
    end

    // Active set: all five parameters load in one edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            params_reg     <= '0;
            active_set_reg <= 1'b0;
        end else begin
            params_reg     <= sel_set;
            active_set_reg <= set_pick;
        end
    end
    assign active_params = params_reg;

    // Select pin: driven as transmit flag unless external select is enabled.
    always_ff @(posedge clk) begin
        if (rst) begin
            set_sel_o_reg <= 1'b0;
        end else begin
            set_sel_o_reg <= (sel_set.mode == MODE_TX);
        end
    end
    assign set_sel_o  = set_sel_o_reg;
    assign set_sel_oe = !ext_sel;

    // Data pin steering.
    assign data_oe = !(bidir && tx_state);
    assign data_o  = rx_data_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_bit_reg <= 1'b0;
        end else if (bidir) begin
            tx_bit_reg <= tx_state ? data_i : 1'b0;
        end else begin
            tx_bit_reg <= transmit_only_input;
        end
    end
    assign tx_bit = tx_bit_reg;

    // Receive data and bit clock: data moves with the falling clock, rises a cycle later.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_data_reg <= 1'b0;
            bclk_reg    <= 1'b0;
        end else begin
            bclk_reg <= !rx_bit_valid;
            if (rx_bit_valid) begin
                rx_data_reg <= rx_bit;
            end
        end
    end
    assign receive_bit_clock = bclk_reg;

    // Pattern recognition over the last received bits, only once the window is full.
    assign match_next = (rx_fill_reg == 6'(PAT_W)) && (rx_shift_reg == pattern);
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_shift_reg <= '0;
            rx_fill_reg  <= 6'h00;
            match_reg    <= 1'b0;
        end else begin
            match_reg <= match_next;
            if (rx_bit_valid) begin
                rx_shift_reg <= {rx_shift_reg[PAT_W-2:0], rx_bit};
                if (rx_fill_reg != 6'(PAT_W)) begin
                    rx_fill_reg <= rx_fill_reg + 6'h01;
                end
            end
        end
    end
    assign pattern_match = match_reg;

    // Reference clock divider.
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt_reg <= 5'h00;
            div_out_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
            div_out_reg <= div_cnt_reg[3'(div_sel) + 3'h1];
        end
    end
    assign divided_ref_clock_out = div_out_reg;

    // Interrupts: sticky, write one to clear, a new event wins over the clear.
    assign irq_event = {IRQ_W{1'b0}} |
                       (IRQ_W'(match_next && !match_reg) << IRQ_MATCH) |
                       (IRQ_W'(set_pick != active_set_reg) << IRQ_SET_CHG);
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status_reg <= IRQ_RESET;
            irq_mask_reg   <= IRQ_RESET;
        end else begin
            if (apb_wr && apb_idx == IDX_IRQ_STATUS) begin
                irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_event;
            end else begin
                irq_status_reg <= irq_status_reg | irq_event;
            end
            if (apb_wr && apb_idx == IDX_IRQ_MASK) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_status_reg & ~irq_mask_reg);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_SET_FROM_REG: assert property (
        !ext_sel |=> active_set_reg == $past(cfg_reg[IDX_SET_SELECT][0]))
        else $error("active set does not follow select register");
    AST_SET_FROM_PIN: assert property (
        ext_sel |=> active_set_reg == $past(set_sel_i))
        else $error("active set does not follow select pin");
    AST_PARAMS_WHOLE: assert property (
        $changed(active_set_reg) |-> params_reg == $past(sel_set))
        else $error("set change did not load whole parameter set");
    AST_SEL_PIN_OUT: assert property (
        (!ext_sel && sel_set.mode == MODE_TX) |=> set_sel_o || $past(ext_sel) == 1'b1)
        else $error("select pin not high in transmit");
    AST_DATA_DIR: assert property (
        (bidir && tx_state) |-> !data_oe)
        else $error("data pin driven during bidirectional transmit");
    AST_DATA_RX_ONLY: assert property (
        !bidir |-> data_oe && data_o == rx_data_reg)
        else $error("data pin not receive output");
    AST_TX_ONLY_IGN: assert property (
        (bidir && !tx_state) |=> !tx_bit)
        else $error("transmit-only input leaked in bidirectional mode");
    AST_BCLK_STEP: assert property (
        (rx_bit_valid ##1 !rx_bit_valid) |-> !receive_bit_clock && data_o == $past(rx_bit)
            ##1 receive_bit_clock)
        else $error("receive data not in step with bit clock");
    AST_DIV_FOUR: assert property (
        (div_sel == 2'h0) [*4] |-> divided_ref_clock_out != $past(divided_ref_clock_out, 2))
        else $error("divide by four period wrong");
    AST_MATCH: assert property (
        match_next |=> pattern_match)
        else $error("pattern match not flagged");
    AST_SER_EN: assert property (
        serial_in.en_n |=> ser_state_reg == SER_IDLE && !serial_out_oe)
        else $error("serial port active while enable high");

endmodule : transceiver_pin_ctrl

// ===== rtl/radio_pkg.sv
// Purpose: Shared constants and types for the transceiver set-select pin logic.
// Assumes: Register indices are byte registers; APB byte address is four times the index.
// Notes: Set #1 occupies indices 6..8 and set #2 indices 9..11, low byte first.
package radio_pkg;

    // Register indices.
    localparam logic [4:0] IDX_SET_SELECT  = 5'h00;
    localparam logic [4:0] IDX_LINK_PARAM2 = 5'h02;
    localparam logic [4:0] IDX_SET1_LO     = 5'h06;
    localparam logic [4:0] IDX_SET2_LO     = 5'h09;
    localparam logic [4:0] IDX_STATUS_LO   = 5'h0C;
    localparam logic [4:0] IDX_STATUS_HI   = 5'h0D;
    localparam logic [4:0] IDX_ADD_PARAM1  = 5'h0E;
    localparam logic [4:0] IDX_PATTERN_LO  = 5'h13;
    localparam logic [4:0] IDX_LAST_CFG    = 5'h16;
    localparam logic [4:0] IDX_IRQ_STATUS  = 5'h18;
    localparam logic [4:0] IDX_IRQ_MASK    = 5'h19;
    localparam int         REG_DEPTH       = 23;

    // Field positions.
    localparam int EXT_SEL_BIT = 3;
    localparam int BIDIR_BIT   = 0;
    localparam int DIV_SEL_LSB = 1;
    localparam int IRQ_MATCH   = 0;
    localparam int IRQ_SET_CHG = 1;
    localparam int IRQ_W       = 2;

    // Reset values and codes.
    localparam logic [7:0]        CFG_RESET  = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RESET  = 2'h0;
    localparam logic [1:0]        MODE_TX    = 2'h3;

    // Serial frame counts and pattern width.
    localparam logic [3:0] HEAD_BITS = 4'h6;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam int         PAT_W     = 32;

    typedef struct packed {
        logic [15:0] freq;
        logic [2:0]  delsig;
        logic        rmode;
        logic [1:0]  power;
        logic [1:0]  mode;
    } param_set_s;

    typedef struct packed {
        logic sck;
        logic si;
        logic en_n;
    } serial_pins_s;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_HEAD = 2'b01,
        SER_DATA = 2'b11,
        SER_DONE = 2'b10
    } ser_state_e;

endpackage : radio_pkg

// ===== verification/mcu_host_model.sv
// Purpose: Behavioural host controller on the far side of the serial port and select line.
// Assumes: Every drive change follows a rising clk edge; each sck phase lasts three clk.
// Notes: Antenna selects exist only as complementary levels; the block has no pins for them.
`timescale 1ns/1ps
module mcu_host_model
    import radio_pkg::*;
(
    // Clock.
    input  wire logic   clk,
    // Serial port.
    input  wire logic   serial_out,
    output serial_pins_s pins,
    // Select line and antenna selects.
    output logic        sel_drive,
    output logic        tx_sel,
    output logic        rx_sel
);
    assign rx_sel = ~tx_sel;

    initial begin
        pins      = '{sck: 1'b0, si: 1'b0, en_n: 1'b1};
        sel_drive = 1'b0;
        tx_sel    = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold

    // Drives the select line and sets the antenna route from is_tx, independent of the line.
    task automatic select(input logic v, input logic is_tx);
        @(posedge clk);
        sel_drive <= v;
        tx_sel    <= is_tx;
    endtask : select

    // Sends the first n_bits of a frame; fewer than 14 aborts it.
    task automatic frame(input logic rd, input logic [4:0] a, input logic [7:0] d,
                         input int n_bits, output logic [7:0] q);
        logic [13:0] bits;
        int          i;
        bits = {rd, a, d};
        q    = 8'h00;
        @(posedge clk);
        pins.en_n <= 1'b0;
        for (int k = 0; k < n_bits; k++) begin
            i = 13 - k;
            pins.si <= bits[i];
            hold(3);
            if (i < 8) q[i] = serial_out;
            pins.sck <= 1'b1;
            hold(3);
            pins.sck <= 1'b0;
        end
        hold(4);
        pins.en_n <= 1'b1;
        pins.si   <= ~pins.si;
        hold(2);
    endtask : frame
endmodule : mcu_host_model

// ===== verification/tb.sv
// Purpose: Self-checking bench for the transceiver set-select pin logic.
// Assumes: APB answers in the first access cycle; outputs are sampled at the falling edge.
// Notes: Random values come from $random with a fixed seed.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb
    import radio_pkg::*;
;
    logic         clk, rst, psel, penable, pwrite, pready, pslverr, irq, e, prev;
    logic [7:0]   paddr, q;
    logic [31:0]  pwdata, prdata, rd, pat;
    serial_pins_s serial_in;
    param_set_s   active_params;
    logic         serial_out, serial_out_oe, set_sel_i, set_sel_o, set_sel_oe, host_sel;
    logic         data_i, data_o, data_oe, tb_data, transmit_only_input, rx_bit, rx_bit_valid;
    logic         tx_bit, receive_bit_clock, pattern_match, divided_ref_clock_out;
    logic [7:0]   s1 [3];
    logic [7:0]   s2 [3];
    int           err_total, check_count, cycles, seed, rises, highs;

    assign set_sel_i = set_sel_oe ? set_sel_o : host_sel;
    assign data_i    = data_oe ? data_o : tb_data;

    transceiver_pin_ctrl #(.ADDR_W(8)) DUT (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .set_sel_i(set_sel_i), .set_sel_o(set_sel_o),
        .set_sel_oe(set_sel_oe), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
        .transmit_only_input(transmit_only_input), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .tx_bit(tx_bit), .active_params(active_params),
        .receive_bit_clock(receive_bit_clock), .pattern_match(pattern_match),
        .divided_ref_clock_out(divided_ref_clock_out), .irq(irq));

    mcu_host_model host (.clk(clk), .serial_out(serial_out), .pins(serial_in),
        .sel_drive(host_sel), .tx_sel(), .rx_sel());

    always #20 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            $display("[ERR] %0t run did not finish in time", $time);
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    function automatic param_set_s exp_set(input logic [7:0] b0, b1, b2);
        return {b2, b1, b0};
    endfunction : exp_set

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        psel   <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        apb({1'b0, idx, 2'b00}, 1'b1, {24'h0, d});
    endtask : wr

    task automatic rdr(input logic [4:0] idx);
        apb({1'b0, idx, 2'b00}, 1'b0, 32'h0);
    endtask : rdr

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic rx_send(input logic b);
        @(posedge clk);
        rx_bit       <= b;
        rx_bit_valid <= 1'b1;
        @(posedge clk);
        rx_bit_valid <= 1'b0;
    endtask : rx_send

    // Source 0 is the shared pin, 1 a forced low, 2 the transmit-only input.
    task automatic tx_try(input int src);
        logic a, b;
        a = 1'($random(seed));
        b = 1'($random(seed));
        @(posedge clk);
        tb_data             <= a;
        transmit_only_input <= b;
        settle(1);
        `CHK(tx_bit, (src == 0) ? a : ((src == 1) ? 1'b0 : b))
    endtask : tx_try

    initial begin
        {clk, psel, penable, pwrite, tb_data, rx_bit, rx_bit_valid} = 7'h00;
        {rst, transmit_only_input, paddr, pwdata} = {1'b1, 1'b0, 8'h00, 32'h0};
        {seed, err_total, check_count, cycles} = {32'd14, 96'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(0);
        `CHK(active_params, param_set_s'(24'h0))
        `CHK({data_oe, set_sel_oe, set_sel_o}, 3'b110)
        apb(8'h5C, 1'b0, 32'h0);
        `CHK({e, rd}, {1'b1, 32'h0})
        apb(8'h01, 1'b0, 32'h0);
        `CHK(e, 1'b1)
        wr(IDX_STATUS_LO, 8'hFF);
        rdr(IDX_STATUS_LO);
        `CHK(rd, 32'h0)
        $display("test reset and refusals done");
        for (int k = 0; k < 3; k++) begin
            s1[k] = 8'($random(seed));
            s2[k] = 8'($random(seed));
        end
        s1[0][1:0] = MODE_TX;
        s2[0][1]   = 1'b0;
        for (int k = 0; k < 3; k++) begin
            wr(5'(IDX_SET1_LO + k), s1[k]);
            wr(5'(IDX_SET2_LO + k), s2[k]);
        end
        rdr(5'(IDX_SET2_LO + 1));
        `CHK(rd, {24'h0, s2[1]})
        wr(IDX_SET_SELECT, 8'h00);
        settle(2);
        `CHK(active_params, exp_set(s1[0], s1[1], s1[2]))
        `CHK(set_sel_o, 1'b1)
        wr(IDX_SET_SELECT, 8'hFF);
        settle(2);
        `CHK(active_params, exp_set(s2[0], s2[1], s2[2]))
        `CHK(set_sel_o, 1'b0)
        rdr(IDX_SET_SELECT);
        `CHK(rd, 32'h1)
        rdr(IDX_IRQ_STATUS);
        `CHK({rd[IRQ_SET_CHG], irq}, 2'b11)
        wr(IDX_IRQ_MASK, 8'h03);
        settle(0);
        `CHK(irq, 1'b0)
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h03);
        rdr(IDX_IRQ_STATUS);
        `CHK({rd, irq}, 33'h0)
        $display("test set selection done");
        host.frame(1'b0, IDX_SET_SELECT, 8'h00, 14, q);
        settle(1);
        `CHK(active_params, exp_set(s1[0], s1[1], s1[2]))
        host.frame(1'b1, 5'h08, 8'h00, 14, q);
        `CHK(q, s1[2])
        host.frame(1'b0, IDX_SET_SELECT, 8'h01, 10, q);
        rdr(IDX_SET_SELECT);
        `CHK(rd, 32'h0)
        $display("test serial port done");
        wr(IDX_SET_SELECT, 8'h01);
        wr(IDX_LINK_PARAM2, 8'(1 << EXT_SEL_BIT));
        host.select(1'b1, 1'b0);
        settle(2);
        `CHK({set_sel_oe, active_params}, {1'b0, exp_set(s2[0], s2[1], s2[2])})
        host.select(1'b0, 1'b1);
        settle(2);
        `CHK(active_params, exp_set(s1[0], s1[1], s1[2]))
        wr(IDX_LINK_PARAM2, 8'h00);
        settle(2);
        `CHK({set_sel_oe, active_params}, {1'b1, exp_set(s2[0], s2[1], s2[2])})
        $display("test external select done");
        wr(IDX_SET_SELECT, 8'h00);
        wr(IDX_ADD_PARAM1, 8'h01);
        settle(1);
        `CHK(data_oe, 1'b0)
        repeat (4) tx_try(0);
        wr(IDX_SET_SELECT, 8'h01);
        settle(2);
        `CHK(data_oe, 1'b1)
        repeat (4) tx_try(1);
        wr(IDX_ADD_PARAM1, 8'h00);
        wr(IDX_SET_SELECT, 8'h00);
        settle(2);
        `CHK(data_oe, 1'b1)
        repeat (4) tx_try(2);
        $display("test data steering done");
        pat = $random(seed);
        for (int k = 0; k < 4; k++) wr(5'(IDX_PATTERN_LO + k), pat[31 - 8 * k -: 8]);
        wr(IDX_IRQ_STATUS, 8'h03);
        rx_send(pat[31]);
        @(negedge clk);
        `CHK({data_o, receive_bit_clock}, {pat[31], 1'b0})
        settle(1);
        `CHK(receive_bit_clock, 1'b1)
        for (int k = 30; k >= 1; k--) rx_send(pat[k]);
        settle(1);
        `CHK({pattern_match, irq}, 2'b00)
        rx_send(pat[0]);
        settle(1);
        `CHK({pattern_match, irq}, 2'b11)
        wr(IDX_IRQ_STATUS, 8'h01);
        settle(1);
        `CHK(irq, 1'b0)
        $display("test receive path done");
        for (int c = 0; c < 4; c++) begin
            wr(IDX_ADD_PARAM1, 8'(c << DIV_SEL_LSB));
            settle(40);
            {rises, highs, prev} = {64'h0, divided_ref_clock_out};
            repeat (256) begin
                @(negedge clk);
                if (divided_ref_clock_out === 1'b1 && prev === 1'b0) rises++;
                if (divided_ref_clock_out === 1'b1) highs++;
                prev = divided_ref_clock_out;
            end
            `CHK(rises, 256 >> (c + 2))
            `CHK(highs, 128)
        end
        $display("test divider done");
        wrap_up();
    end
endmodule : tb
